// ==== dip_switch_address_config.v ====
`timescale 1ns/1ps
`include "dip_config_regs.vh"
module dip_switch_address_config
#(
   parameter NDIFF = 4                 // Number of differential outputs
)
(
   // Clock and reset
   input  wire             CLK,        // 25 MHz clock
   input  wire             RST_N,      // Async reset, active low
   // Board switches
   input  wire [7:0]       DIP_SW,     // Switches 1..8, ON = 1
   // Register bus
   input  wire             PSEL,       // APB select
   input  wire             PENABLE,    // APB enable
   input  wire             PWRITE,     // APB direction
   input  wire [11:0]      PADDR,      // APB byte address
   input  wire [31:0]      PWDATA,     // APB write data
   output wire             PREADY,     // APB ready
   output reg  [31:0]      PRDATA,     // APB read data
   output wire             PSLVERR,    // APB error
   // Differential outputs
   input  wire [NDIFF-1:0] DIFF_CMD,   // Software output levels
   output wire [NDIFF-1:0] DIFF_OUT,   // Differential output level
   output wire [NDIFF-1:0] DIFF_OE,    // Differential driver enable
   // Captured identity for the communication stacks
   output reg  [31:0]      EFF_IP,     // Effective IP address
   output reg  [15:0]      EFF_PORT,   // Effective port
   output reg  [7:0]       EFF_NODE,   // Effective node address
   output wire [31:0]      BAUD,       // Baud setting, passed through
   output wire             CFG_VALID   // Switches captured
);
   // Software-visible configuration
   reg  [31:0]      base_ip_reg;       // Base IP (base_ip_octet_table)
   reg  [15:0]      base_port_reg;     // Base port
   reg  [7:0]       base_node_reg;     // base_node_address
   reg  [31:0]      baud_reg;          // Baud setting
   reg  [NDIFF-1:0] diff_en_reg;       // Output enables
   // Internal wiring
   wire [7:0]       snap;              // Captured switches
   wire             done;              // Capture done
   wire [2:0]       offset;            // Address offset
   wire             force_def;         // Force defaults switch
   wire             wr;                // Write strobe
   wire             rd;                // Read strobe
   reg              hit;               // Address mapped

   // One-time switch capture. The bank is read at the first edge after
   // reset and then frozen, so a switch moved while running only takes
   // effect at the next reset. Switch 1 is a purely analogue terminator
   // and is captured only so that the snapshot shows the whole bank.
   switch_capture #(.W(8)) u_cap
   (
      .CLK   (CLK),
      .RST_N (RST_N),
      .SW_IN (DIP_SW),
      .SNAP  (snap),
      .DONE  (done)
   );

   // Effective values can be trusted one cycle after CFG_VALID rises
   assign CFG_VALID = done;
   // Switch 4 weighs four, switch 5 two and switch 6 one
   assign offset    = {snap[`SW_OFF_MSB], snap[`SW_OFF_MID], snap[`SW_OFF_LSB]}
                      & {3{done}};                                   // [R4]
   // Force switch only acts once the bank has been captured
   assign force_def = snap[`SW_FORCE] & done;                        // [R2]
   // Switches 2, 7, 8 are assumed OFF and are not acted on   [R9]
   assign BAUD      = baud_reg;                                      // [R3]

   // APB strobes. The slave never stalls: PREADY is tied high, so
   // every access phase lasts exactly one cycle and a write lands
   // on the rising edge that closes it. Unmapped addresses raise
   // PSLVERR in the access phase; the write is dropped, a read gives 0.
   assign wr      = PSEL & PENABLE & PWRITE;
   assign rd      = PSEL & PENABLE & ~PWRITE;
   assign PREADY  = 1'b1;
   assign PSLVERR = PSEL & PENABLE & ~hit;

   // Address decode; one word per register, byte addresses
   //   000 switch snapshot, read only (diagnostic query)
   //   004 base IP address, low octet takes the offset
   //   008 base port
   //   00C base node address
   //   010 effective IP, read only
   //   014 effective port, read only
   //   018 effective node address, read only
   //   01C differential output enables
   //   020 baud setting, never touched by the force switch
   always @*
   begin
      // Snapshot
      if (PADDR == `ADDR_SNAPSHOT)
         hit = 1'b1;
      // Base IP
      else if (PADDR == `ADDR_BASE_IP)
         hit = 1'b1;
      // Base port
      else if (PADDR == `ADDR_BASE_PORT)
         hit = 1'b1;
      // Base node address
      else if (PADDR == `ADDR_BASE_NODE)
         hit = 1'b1;
      // Effective IP
      else if (PADDR == `ADDR_EFF_IP)
         hit = 1'b1;
      // Effective port
      else if (PADDR == `ADDR_EFF_PORT)
         hit = 1'b1;
      // Effective node address
      else if (PADDR == `ADDR_EFF_NODE)
         hit = 1'b1;
      // Output enables
      else if (PADDR == `ADDR_DIFF_EN)
         hit = 1'b1;
      // Baud setting
      else if (PADDR == `ADDR_BAUD)
         hit = 1'b1;
      // Nothing mapped here
      else
         hit = 1'b0;
   end

   // Writable configuration registers
   always @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         base_ip_reg   <= `RST_BASE_IP;
         base_port_reg <= `RST_BASE_PORT;
         base_node_reg <= `RST_BASE_NODE;
         baud_reg      <= `RST_BAUD;
         diff_en_reg   <= {NDIFF{`RST_DIFF_EN}};                     // [R1]
      end
      else if (wr)
      begin
         // Base IP, whole word
         if (PADDR == `ADDR_BASE_IP)
            base_ip_reg <= PWDATA;
         // Base port, low half
         else if (PADDR == `ADDR_BASE_PORT)
            base_port_reg <= PWDATA[15:0];
         // Base node address, low byte
         else if (PADDR == `ADDR_BASE_NODE)
            base_node_reg <= PWDATA[7:0];
         // Software takes control of the outputs here
         else if (PADDR == `ADDR_DIFF_EN)
            diff_en_reg <= PWDATA[NDIFF-1:0];                        // [R1]
         // Baud setting, whole word
         else if (PADDR == `ADDR_BAUD)
            baud_reg <= PWDATA;
      end
   end

   // Outputs stay off until software enables each one; the level is
   // gated as well, so a disabled driver never shows a stale command
   // even if the pad logic ignores the enable.
   assign DIFF_OE  = diff_en_reg;                                    // [R1]
   assign DIFF_OUT = DIFF_CMD & diff_en_reg;                         // [R1]

   // Effective identity, registered; follows a base write one cycle later
   // and is meaningful from the second edge after reset release.
   always @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         EFF_IP   <= 32'h00000000;
         EFF_PORT <= 16'h0000;
         EFF_NODE <= 8'h00;
      end
      // Force switch replaces address, IP and port, never baud
      else if (force_def)
      begin
         EFF_IP   <= `DEF_IP;                                        // [R2]
         EFF_PORT <= `DEF_PORT;                                      // [R2]
         EFF_NODE <= `DEF_NODE;                                      // [R2]
      end
      else
      begin
         // Normal path: IP is base plus the switch offset, node is base plus 16 times the offset, port is the base
         // Low octet sum wraps in eight bits
         EFF_IP   <= {base_ip_reg[31:8],
                      base_ip_reg[7:0] + {5'h00, offset}};           // [R5] [R10]
         EFF_PORT <= base_port_reg;
         EFF_NODE <= base_node_reg
                     + {1'b0, offset, {`NODE_SHIFT{1'b0}}};          // [R6]
      end
   end

   // Read mux; snapshot register is the diagnostic query
   always @*
   begin
      PRDATA = 32'h00000000;
      if (rd)
      begin
         // Switch bank as captured, with the capture flag above it
         if (PADDR == `ADDR_SNAPSHOT)
            PRDATA = {23'h000000, done, snap};                       // [R8]
         // Base IP
         else if (PADDR == `ADDR_BASE_IP)
            PRDATA = base_ip_reg;
         // Base port
         else if (PADDR == `ADDR_BASE_PORT)
            PRDATA = {16'h0000, base_port_reg};
         // Base node address
         else if (PADDR == `ADDR_BASE_NODE)
            PRDATA = {24'h000000, base_node_reg};
         // Effective IP
         else if (PADDR == `ADDR_EFF_IP)
            PRDATA = EFF_IP;
         // Effective port
         else if (PADDR == `ADDR_EFF_PORT)
            PRDATA = {16'h0000, EFF_PORT};
         // Effective node address
         else if (PADDR == `ADDR_EFF_NODE)
            PRDATA = {24'h000000, EFF_NODE};
         // Output enables
         else if (PADDR == `ADDR_DIFF_EN)
            PRDATA = {{(32-NDIFF){1'b0}}, diff_en_reg};
         // Baud setting
         else if (PADDR == `ADDR_BAUD)
            PRDATA = baud_reg;
      end
   end
endmodule // dip_switch_address_config

// ==== dip_config_regs.vh ====
// Summary of operation
// R1: Differential outputs disabled until software enables them
// R2: Force switch ON selects fixed IP, port, node
// R3: Force switch leaves baud-rate settings untouched
// R4: Offset from switches 4-5-6, switch 4 MSB
// R5: Fourth IP octet is base plus offset
// R6: Node address is base plus offset times 16
// R7: Switches sampled once after reset only
// R8: Captured switches readable by diagnostic query
// R9: User keeps switches 2, 7, 8 OFF
// R10: IP octet sum wraps modulo 256
`ifndef DIP_CONFIG_REGS_VH
`define DIP_CONFIG_REGS_VH
// Register byte addresses
`define ADDR_SNAPSHOT   12'h000
`define ADDR_BASE_IP    12'h004
`define ADDR_BASE_PORT  12'h008
`define ADDR_BASE_NODE  12'h00C
`define ADDR_EFF_IP     12'h010
`define ADDR_EFF_PORT   12'h014
`define ADDR_EFF_NODE   12'h018
`define ADDR_DIFF_EN    12'h01C
`define ADDR_BAUD       12'h020
// Switch positions inside the 8-bit bank (switch n at bit n-1)
`define SW_FORCE        2
`define SW_OFF_MSB      3
`define SW_OFF_MID      4
`define SW_OFF_LSB      5
// Forced defaults: 172.1.1.101, port 50000, node 64
`define DEF_IP          32'hAC010165
`define DEF_PORT        16'hC350
`define DEF_NODE        8'h40
// Node offset scale shift (times 16)
`define NODE_SHIFT      4
// Reset values
`define RST_BASE_IP     32'hC0A80001
`define RST_BASE_PORT   16'hC350
`define RST_BASE_NODE   8'h01
`define RST_BAUD        32'h0001C200
`define RST_DIFF_EN     1'b0
`endif

// ==== switch_capture.v ====
`timescale 1ns/1ps
`include "dip_config_regs.vh"
module switch_capture
#(
   parameter W = 8                  // Switch bank width
)
(
   input  wire         CLK,         // System clock
   input  wire         RST_N,       // Async reset, active low
   input  wire [W-1:0] SW_IN,       // Raw switch levels
   output reg  [W-1:0] SNAP,        // Captured switches
   output reg          DONE         // Capture has happened
);
   // Capture once at the first edge after reset release, then freeze
   always @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         SNAP <= {W{1'b0}};
         DONE <= 1'b0;
      end
      else if (!DONE)
      begin
         SNAP <= SW_IN;            // [R7]
         DONE <= 1'b1;             // [R7]
      end
   end
endmodule // switch_capture

// ==== dip_switch_address_config_monitor.sv ====
`timescale 1ns/1ps
`include "dip_config_regs.vh"
module dip_switch_address_config_monitor
#(parameter NDIFF = 4)
(
   input wire             CLK,       // Clock
   input wire             RST_N,     // Reset
   input wire [7:0]       DIP_SW,    // Switches
   input wire             PSEL,      // Select
   input wire             PENABLE,   // Enable
   input wire             PWRITE,    // Write
   input wire [11:0]      PADDR,     // Address
   input wire [31:0]      PWDATA,    // Write data
   input wire [31:0]      PRDATA,    // Read data
   input wire [NDIFF-1:0] DIFF_OUT,  // Levels
   input wire [NDIFF-1:0] DIFF_OE,   // Enables
   input wire [31:0]      EFF_IP,    // IP
   input wire [15:0]      EFF_PORT,  // Port
   input wire [7:0]       EFF_NODE,  // Node
   input wire [31:0]      BAUD,      // Baud
   input wire             CFG_VALID  // Captured
);
   reg  [7:0]  snap;                                  // Captured switches
   reg  [31:0] bip;                                   // Base IP copy
   reg  [7:0]  bnd;                                   // Base node copy
   wire        wr  = PSEL && PENABLE && PWRITE;       // Write taken
   wire [7:0]  off = {5'h0, snap[3], snap[4], snap[5]}; // Switch 4 is MSB
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   // Shadow the capture and the base writes
   always @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         snap <= 8'h00;
         bip  <= `RST_BASE_IP;
         bnd  <= `RST_BASE_NODE;
      end
      else
      begin
         if (!CFG_VALID) snap <= DIP_SW;
         if (wr && PADDR == `ADDR_BASE_IP) bip <= PWDATA;
         if (wr && PADDR == `ADDR_BASE_NODE) bnd <= PWDATA[7:0];
      end
   end
   diff_gate_a: assert property ((DIFF_OUT & ~DIFF_OE) == 0)
      else $error("Output driven while disabled");
   diff_hold_a: assert property (!(wr && PADDR == `ADDR_DIFF_EN) |=> $stable(DIFF_OE))
      else $error("Enable changed without write");
   force_def_a: assert property (CFG_VALID && $past(CFG_VALID) && snap[2] |->
      EFF_IP == `DEF_IP && EFF_PORT == `DEF_PORT && EFF_NODE == `DEF_NODE)
      else $error("Forced values wrong");
   ip_sum_a: assert property (CFG_VALID && $past(CFG_VALID) && !snap[2] |->
      {EFF_IP[31:8], EFF_IP[7:0] - off} == $past(bip)) else $error("IP offset wrong");
   node_sum_a: assert property (CFG_VALID && $past(CFG_VALID) && !snap[2] |->
      EFF_NODE - (off << 4) == $past(bnd)) else $error("Node offset wrong");
   eff_hold_a: assert property (CFG_VALID && $past(CFG_VALID) && !$past(wr) |=>
      $stable(EFF_IP) && $stable(EFF_NODE)) else $error("Effective value moved");
   snap_read_a: assert property (CFG_VALID && PSEL && PENABLE && !PWRITE &&
      PADDR == `ADDR_SNAPSHOT |-> PRDATA == {23'h0, 1'b1, snap}) else $error("Snapshot wrong");
   baud_keep_a: assert property (!(wr && PADDR == `ADDR_BAUD) |=> $stable(BAUD))
      else $error("Baud changed without write");
   cover property (CFG_VALID && snap[2]);
   cover property (CFG_VALID && off == 8'h07);
   cover property (wr && PADDR == `ADDR_DIFF_EN);
endmodule // dip_switch_address_config_monitor
bind dip_switch_address_config dip_switch_address_config_monitor #(.NDIFF(NDIFF)) mon_inst
(.CLK(CLK), .RST_N(RST_N), .DIP_SW(DIP_SW), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
 .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .DIFF_OUT(DIFF_OUT), .DIFF_OE(DIFF_OE),
 .EFF_IP(EFF_IP), .EFF_PORT(EFF_PORT), .EFF_NODE(EFF_NODE), .BAUD(BAUD), .CFG_VALID(CFG_VALID));

// ==== dip_bank_model.sv ====
`timescale 1ns/1ps
module dip_bank_model
(
   input  wire [7:0] req, // Wanted positions
   output wire [7:0] sw   // Levels on the board
);
   // Switches 2, 7 and 8 are kept OFF by the user
   assign sw = req & 8'h3D;
endmodule // dip_bank_model

// ==== tb_dip_switch_address_config.sv ====
`timescale 1ns/1ps
module tb_dip_switch_address_config;
   reg         CLK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0; // Drives
   reg  [11:0] PADDR = 0;                         // Address
   reg  [31:0] PWDATA = 0, rd, bip, bnd, bd, en, bp; // Bus data and stimulus
   reg         er;                                // Error flag of last transfer
   reg  [3:0]  DIFF_CMD = 0;                      // Output levels
   reg  [7:0]  req = 0, sw;                       // Switch stimulus
   wire [7:0]  DIP_SW, EFF_NODE;                  // Switches, node
   wire        PREADY, PSLVERR, CFG_VALID;        // Status
   wire [31:0] PRDATA, EFF_IP, BAUD;              // Outputs
   wire [15:0] EFF_PORT;                          // Port
   wire [3:0]  DIFF_OUT, DIFF_OE;                 // Differential
   integer     err_count = 0, n_checks = 0, i;    // Counters
   always #20 CLK = ~CLK;
   dip_bank_model dip_bank_model_inst (.req(req), .sw(DIP_SW));
   dip_switch_address_config dip_switch_address_config_inst (.CLK(CLK), .RST_N(RST_N),
      .DIP_SW(DIP_SW), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
      .PWDATA(PWDATA), .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
      .DIFF_CMD(DIFF_CMD), .DIFF_OUT(DIFF_OUT), .DIFF_OE(DIFF_OE), .EFF_IP(EFF_IP),
      .EFF_PORT(EFF_PORT), .EFF_NODE(EFF_NODE), .BAUD(BAUD), .CFG_VALID(CFG_VALID));
   task results;
   begin
      if (err_count == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   end
   endtask
   task chk(input string nm, input [31:0] e, input [31:0] s);
   begin
      n_checks++;
      if (e !== s)
      begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   end
   endtask
   // One APB transfer; read data lands in rd
   task apb(input w, input [11:0] a, input [31:0] d);
   begin
      PSEL <= 1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1;
      @(posedge CLK);
      while (PREADY !== 1'b1) @(posedge CLK);
      rd = PRDATA;
      er = PSLVERR;
      PSEL <= 0;
      PENABLE <= 0;
      @(posedge CLK);
   end
   endtask
   function [31:0] ip_x(input [31:0] b, input [7:0] s);
      ip_x = s[2] ? 32'hAC010165 : {b[31:8], b[7:0] + {5'h0, s[3], s[4], s[5]}};
   endfunction
   function [7:0] nd_x(input [7:0] b, input [7:0] s);
      nd_x = s[2] ? 8'h40 : b + {1'b0, s[3], s[4], s[5], 4'h0};
   endfunction
   function [31:0] pt_x(input [15:0] b, input [7:0] s);
      pt_x = {16'h0, s[2] ? 16'hC350 : b};
   endfunction
   // Cut a hang short
   initial
   begin
      #200000;
      err_count++;
      results;
   end
   // Capture, override and offset passes, each after a fresh reset
   initial
   begin
      i = $urandom(85);
      for (i = 0; i < 8; i++)
      begin
         en = $urandom;
         sw = (i == 0) ? 8'h38 : (i == 1) ? 8'h3C : en[7:0];
         req <= sw;
         DIFF_CMD <= en[11:8];
         RST_N <= 0;
         repeat (16) @(posedge CLK);
         RST_N <= 1;
         repeat (3) @(posedge CLK);
         sw = sw & 8'h3D;
         apb(0, 12'h000, 0);
         chk("snapshot", {23'h0, 1'b1, sw}, rd);
         chk("diff_off", 0, {DIFF_OUT, DIFF_OE});
         chk("slverr_ok", 0, {31'h0, er});
         bip = (i == 0) ? 32'h0A0000FF : $urandom;
         bnd = $urandom;
         bd = $urandom;
         apb(1, 12'h004, bip);
         apb(1, 12'h00C, bnd);
         apb(1, 12'h020, bd);
         bp = $urandom;
         apb(1, 12'h008, bp);
         req <= ~sw;
         apb(0, 12'h010, 0);
         chk("eff_ip", ip_x(bip, sw), rd);
         apb(0, 12'h018, 0);
         chk("eff_node", {24'h0, nd_x(bnd[7:0], sw)}, rd);
         chk("eff_ip_pin", ip_x(bip, sw), EFF_IP);
         apb(0, 12'h014, 0);
         chk("eff_port", pt_x(bp[15:0], sw), rd);
         chk("eff_port_pin", pt_x(bp[15:0], sw), {16'h0, EFF_PORT});
         chk("baud", bd, BAUD);
         apb(0, 12'h000, 0);
         chk("snap_hold", {23'h0, 1'b1, sw}, rd);
         en = $urandom;
         apb(1, 12'h01C, en);
         chk("diff_out", {28'h0, DIFF_CMD & en[3:0]}, {28'h0, DIFF_OUT});
         chk("diff_oe", {28'h0, en[3:0]}, {28'h0, DIFF_OE});
         apb(0, 12'h024, 0);
         chk("unmapped", 0, rd);
         chk("slverr", 1, {31'h0, er});
      end
      results;
   end
endmodule // tb_dip_switch_address_config
